/* File: dpc_defines.vh */
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH

// ----------------------------------------------------------------------
// power states
// ----------------------------------------------------------------------
`define DPC_ST_IDLE 3'h0
`define DPC_ST_ACTIVE 3'h1
`define DPC_ST_PPD 3'h2
`define DPC_ST_APD 3'h3
`define DPC_ST_SREF 3'h4
`define DPC_ST_BUSY 3'h5

// ----------------------------------------------------------------------
// command codes {ras_n, cas_n, we_n} with cs_n low
// ----------------------------------------------------------------------
`define DPC_CMD_NOP 3'h7
`define DPC_CMD_REF 3'h1
`define DPC_CMD_MRS 3'h0

// ----------------------------------------------------------------------
// exit and mode timing defaults in clock cycles
// ----------------------------------------------------------------------
`define DPC_TXP_CYC 8'h03
`define DPC_TXS_CYC 8'h10
`define DPC_TXSDLL_CYC 16'h0200
`define DPC_TMOD_CYC 8'h0c

`endif

/* File: dpc_cke_power.v */
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`include "dpc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module dpc_cke_power #(
   parameter [7:0] TXP_CYC = `DPC_TXP_CYC,
   parameter [7:0] TXS_CYC = `DPC_TXS_CYC,
   parameter [15:0] TXSDLL_CYC = `DPC_TXSDLL_CYC,
   parameter [7:0] TMOD_CYC = `DPC_TMOD_CYC
) (
   input wire MCLK_IN, // 25 mhz core clock
   input wire ARST_N_IN, // async reset, active low
   input wire CKE_IN, // clock enable pin
   input wire CS_N_IN, // chip select, active low
   input wire RAS_N_IN, // row strobe, active low
   input wire CAS_N_IN, // column strobe, active low
   input wire WE_N_IN, // write enable, active low
   input wire ODT_IN, // termination request pin
   input wire BANKS_OPEN_IN, // any bank open, core logic
   input wire BURST_BUSY_IN, // burst or precharge running, core logic
   output reg [2:0] STATE_OUT, // current power state
   output reg IDLE_OUT, // device idle
   output reg CMD_VALID_OUT, // command accepted this edge
   output reg ODT_EN_OUT, // termination enabled
   output reg REFRESH_EN_OUT, // internal refresh engine running
   output reg ILLEGAL_OUT, // illegal command at transition, pulse
   output reg WRITE_OK_OUT, // writes / leveling allowed
   output reg READ_OK_OUT // reads / odt allowed
);

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   reg [4:0] pin_s1_q;
   reg [4:0] pin_s2_q;
   reg odt_s1_q;
   reg odt_s2_q;

   // two stages on every pin; the first stage feeds nothing else
   // cke and command share one delay, so each pair still meets its command
   always @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         pin_s1_q <= 5'h0f;
         pin_s2_q <= 5'h0f;
         odt_s1_q <= 1'b0;
         odt_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= {CKE_IN, CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN};
         pin_s2_q <= pin_s1_q;
         odt_s1_q <= ODT_IN;
         odt_s2_q <= odt_s1_q;
      end
   end

   // current synced cke; the previous level is kept one stage further on
   wire cke_cur = pin_s2_q[4];
   reg cke_prev_q;

   // -------------------------------------------------------------------
   // command decode
   // -------------------------------------------------------------------
   // nop or deselect, shared by all transition checks
   function is_nop;
      input [3:0] c;
      begin
         is_nop = c[3] | (c[2:0] == `DPC_CMD_NOP);
      end
   endfunction

   wire [3:0] cmd = pin_s2_q[3:0];
   wire cmd_nop = is_nop(cmd);
   wire cmd_ref = ~cmd[3] & (cmd[2:0] == `DPC_CMD_REF);
   wire cmd_mrs = ~cmd[3] & (cmd[2:0] == `DPC_CMD_MRS);

   // -------------------------------------------------------------------
   // state and timers
   // -------------------------------------------------------------------
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [7:0] xp_q;
   reg [7:0] xs_q;
   reg [15:0] xdll_q;
   reg [7:0] mod_q;
   reg illegal_d;
   reg sr_exit;
   reg pd_exit;

   // power-down exit, self refresh exit and mode timers all count toward idle
   wire timers_done = (xp_q == 8'h00) && (xs_q == 8'h00) && (mod_q == 8'h00);
   // bank and burst status arrive on this clock with no sync delay, so they
   // lead the pins by two cycles; the controller's own spacing covers that
   wire idle_base = !BANKS_OPEN_IN && !BURST_BUSY_IN && timers_done;
   // idle only with banks closed, no burst, cke high, timings met
   wire idle_now = idle_base && cke_cur;
   // states in which cke low is the normal level
   wire low_power = (state_q == `DPC_ST_PPD) || (state_q == `DPC_ST_APD) ||
                    (state_q == `DPC_ST_SREF);

   // next state from previous/current cke pair and state before the edge
   always @* begin
      state_d = state_q;
      illegal_d = 1'b0;
      sr_exit = 1'b0;
      pd_exit = 1'b0;
      case ({cke_prev_q, cke_cur})
         2'b00: begin
            // pins may float while cke stays low; nothing here reads the command
            state_d = state_q;
         end
         2'b01: begin
            if (low_power) begin
               // exit is taken from the cke level alone; no clock history used
               illegal_d = !cmd_nop;
               if (state_q == `DPC_ST_SREF) begin
                  sr_exit = 1'b1;
                  state_d = `DPC_ST_IDLE;
               end else begin
                  pd_exit = 1'b1;
                  state_d = (state_q == `DPC_ST_APD) ? `DPC_ST_ACTIVE : `DPC_ST_IDLE;
               end
            end
         end
         2'b10: begin
            // the idle test uses the cke level of the previous edge; the
            // current low level is the entry itself and must not veto it
            if (cmd_ref && state_q == `DPC_ST_IDLE && idle_base && cke_prev_q) begin
               state_d = `DPC_ST_SREF;
            end else begin
               illegal_d = !cmd_nop;
               // bank state when the last command ends picks the mode
               state_d = BANKS_OPEN_IN ? `DPC_ST_APD : `DPC_ST_PPD;
            end
         end
         2'b11: begin
            // cke high at both edges: open banks make it active, a running burst alone makes it busy
            if (BANKS_OPEN_IN || BURST_BUSY_IN) begin
               state_d = BANKS_OPEN_IN ? `DPC_ST_ACTIVE : `DPC_ST_BUSY;
            end else begin
               state_d = `DPC_ST_IDLE;
            end
         end
         default: begin
            state_d = state_q;
         end
      endcase
   end

   // state register and exit/mode timers
   always @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_q <= `DPC_ST_IDLE;
         cke_prev_q <= 1'b0;
         xp_q <= 8'h00;
         xs_q <= 8'h00;
         xdll_q <= 16'h0000;
         mod_q <= 8'h00;
      end else begin
         cke_prev_q <= cke_cur;
         state_q <= state_d;
         // timers only count down; a new exit, or a mode write for the mode timer, simply reloads them
         xp_q <= pd_exit ? TXP_CYC : ((xp_q != 8'h00) ? xp_q - 8'h01 : 8'h00);
         xs_q <= sr_exit ? TXS_CYC : ((xs_q != 8'h00) ? xs_q - 8'h01 : 8'h00);
         // 512-cycle guard after self refresh exit also gates writes
         xdll_q <= sr_exit ? TXSDLL_CYC : ((xdll_q != 16'h0000) ? xdll_q - 16'h0001 : 16'h0000);
         if (cke_prev_q && cke_cur && cmd_mrs)
            mod_q <= TMOD_CYC;
         else if (mod_q != 8'h00)
            mod_q <= mod_q - 8'h01;
      end
   end

   // -------------------------------------------------------------------
   // registered outputs
   // -------------------------------------------------------------------
   // odt pin never steers state; it only gates the termination output
   always @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         STATE_OUT <= `DPC_ST_IDLE;
         IDLE_OUT <= 1'b0;
         CMD_VALID_OUT <= 1'b0;
         ODT_EN_OUT <= 1'b0;
         REFRESH_EN_OUT <= 1'b0;
         ILLEGAL_OUT <= 1'b0;
         WRITE_OK_OUT <= 1'b0;
         READ_OK_OUT <= 1'b0;
      end else begin
         STATE_OUT <= state_d;
         IDLE_OUT <= idle_now && (state_d == `DPC_ST_IDLE);
         CMD_VALID_OUT <= cke_prev_q && cke_cur && !cmd_nop;
         ODT_EN_OUT <= odt_s2_q && (state_d != `DPC_ST_SREF);
         REFRESH_EN_OUT <= (state_d == `DPC_ST_SREF);
         // illegal transitions are flagged but still taken, so state tracks the pins
         ILLEGAL_OUT <= illegal_d;
         // both gates wait the whole dll time; a shorter read wait is not modelled
         WRITE_OK_OUT <= (xdll_q == 16'h0000) && !sr_exit && cke_cur;
         READ_OK_OUT <= (xdll_q == 16'h0000) && !sr_exit && cke_cur;
      end
   end

endmodule

`default_nettype wire

/* File: dpc_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---
// controller model
// ---
module dpc_ctrl_model (
   input wire logic clk_in, // core clock
   output logic cke_out, // clock enable
   output logic [3:0] cmd_out, // cs_n ras_n cas_n we_n
   output logic odt_out // termination
);
   initial {cke_out, cmd_out, odt_out} = 6'h0e;
   // hold a cke level n cycles; pins float while cke stays low
   task automatic step(input logic c, input logic [3:0] k, input logic o, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_in);
         cke_out <= c;
         odt_out <= o;
         cmd_out <= (!c && i > 0) ? 4'($urandom) : k;
      end
   endtask
endmodule
`default_nettype wire

/* File: dpc_cke_power_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"
// ---
// power state checks
// ---
module dpc_cke_power_sva (
   input wire logic MCLK_IN, // core clock
   input wire logic ARST_N_IN, // async reset, active low
   input wire logic CKE_IN, // clock enable pin
   input wire logic CMD_VALID_OUT, // command accepted
   input wire logic ODT_EN_OUT, // termination enabled
   input wire logic REFRESH_EN_OUT, // internal refresh running
   input wire logic WRITE_OK_OUT, // writes allowed
   input wire logic READ_OK_OUT, // reads allowed
   input wire logic [2:0] STATE_OUT // power state
);
   // five-sample cke runs cover the sync delay
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   wire lp = STATE_OUT >= `DPC_ST_PPD && STATE_OUT <= `DPC_ST_SREF;
   wire sr = STATE_OUT == `DPC_ST_SREF;
   odt_sref_a: assert property (sr && $past(sr) |-> !ODT_EN_OUT)
      else $error("odt in self refresh");
   pd_refresh_a: assert property (lp && !sr |-> !REFRESH_EN_OUT)
      else $error("refresh in power-down");
   low_cmd_a: assert property (lp |-> !CMD_VALID_OUT)
      else $error("command taken in low power");
   low_gate_a: assert property (lp && $past(lp) |-> !WRITE_OK_OUT && !READ_OK_OUT)
      else $error("access open in low power");
   low_hold_a: assert property ((!CKE_IN)[*5] ##0 lp |=> $stable(STATE_OUT))
      else $error("low power left with cke low");
   sref_exit_a: assert property (CKE_IN[*5] |-> !sr)
      else $error("self refresh kept");
   sref_entry_a: assert property (sr && !$past(sr) |-> $past(STATE_OUT) == 3'h0)
      else $error("self refresh from non-idle");
   exit_write_a: assert property ($fell(sr) |-> (!WRITE_OK_OUT)[*8])
      else $error("early write after exit");
endmodule
`default_nettype wire

/* File: dpc_cke_power_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"
// ---
// bench top
// ---
module dpc_cke_power_tb_top;
   localparam logic [3:0] NOP = 4'h7;
   localparam logic [3:0] REF = 4'h1;
   localparam logic [3:0] MRS = 4'h0;
   logic mclk, arst_n, bk, cke, odt;
   logic [3:0] cmd;
   wire [2:0] st;
   wire cv, oe, re, ill, wok, rok, idl;
   int fails, checks_done, n, ill_n, cv_n, base;
   logic [2:0] exp_q[$];
   event look;
   dpc_ctrl_model u_ctrl (.clk_in(mclk), .cke_out(cke), .cmd_out(cmd), .odt_out(odt));
   // short dll wait keeps the run brief
   dpc_cke_power #(.TXSDLL_CYC(16'h0010)) u_dut (.MCLK_IN(mclk), .ARST_N_IN(arst_n),
      .CKE_IN(cke), .CS_N_IN(cmd[3]), .RAS_N_IN(cmd[2]), .CAS_N_IN(cmd[1]),
      .WE_N_IN(cmd[0]), .ODT_IN(odt), .BANKS_OPEN_IN(bk), .BURST_BUSY_IN(1'b0),
      .STATE_OUT(st), .IDLE_OUT(idl), .CMD_VALID_OUT(cv), .ODT_EN_OUT(oe),
      .REFRESH_EN_OUT(re), .ILLEGAL_OUT(ill), .WRITE_OK_OUT(wok), .READ_OK_OUT(rok));
   task automatic check(input logic [2:0] s, input logic [2:0] e, input string w);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, s);
      end
   endtask
   // note the settled state after each cke step
   task automatic go(input logic c, input logic [3:0] k, input logic o, input logic [2:0] s);
      u_ctrl.step(c, k, o, 10);
      #1 exp_q.push_back(s);
      -> look;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(look) check(st, exp_q.pop_front(), "state");
   // count one-cycle pulses; the counts are read only between controller steps
   always @(posedge mclk) begin
      if (ill === 1'b1) ill_n <= ill_n + 1;
      if (cv === 1'b1) cv_n <= cv_n + 1;
   end
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      void'($urandom(32'h071c431f));
      {arst_n, bk} = 2'h0;
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      go(1, NOP, 0, 3'h0);
      check(idl, 1'b1, "idle");
      go(0, NOP, 0, 3'h2);
      check(re, 1'b0, "refresh");
      go(1, NOP, 0, 3'h0);
      $display("test power-down done");
      @(posedge mclk) bk <= 1'b1;
      go(1, NOP, 0, 3'h1);
      check(idl, 1'b0, "idle");
      go(0, REF, 0, 3'h3);
      go(1, NOP, 0, 3'h1);
      @(posedge mclk) bk <= 1'b0;
      base = ill_n;
      u_ctrl.step(0, 4'h3, 0, 10);
      check(ill_n == base + 1, 1'b1, "illegal");
      u_ctrl.step(1, NOP, 0, 3);
      arst_n <= 1'b0;
      u_ctrl.step(1, NOP, 0, 3);
      arst_n <= 1'b1;
      $display("test illegal done");
      go(1, NOP, 1, 3'h0);
      check(oe, 1'b1, "odt");
      go(0, REF, 1, 3'h4);
      check(oe, 1'b0, "odt");
      check(re, 1'b1, "refresh");
      base = ill_n;
      u_ctrl.step(1, NOP, 0, 1);
      // bounded wait, one count per edge from the edge that raises cke
      for (n = 0; n < 100 && wok !== 1'b1; n++) @(posedge mclk);
      check(n >= 16 && n < 100, 1'b1, "dll wait");
      check(rok, 1'b1, "read gate");
      check(ill_n == base, 1'b1, "illegal");
      $display("test self refresh done");
      // a mode write starts the mode timer, which holds idle off meanwhile
      base = cv_n;
      u_ctrl.step(1, MRS, 0, 1);
      u_ctrl.step(1, NOP, 0, 4);
      #1 check(idl, 1'b0, "idle");
      u_ctrl.step(1, NOP, 0, 12);
      #1 check(idl, 1'b1, "idle");
      check(cv_n == base + 1, 1'b1, "cmd valid");
      $display("test mode timer done");
      final_report;
   end
endmodule
bind dpc_cke_power dpc_cke_power_sva u_sva (.MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN),
   .CKE_IN(CKE_IN), .CMD_VALID_OUT(CMD_VALID_OUT), .ODT_EN_OUT(ODT_EN_OUT),
   .REFRESH_EN_OUT(REFRESH_EN_OUT), .WRITE_OK_OUT(WRITE_OK_OUT),
   .READ_OK_OUT(READ_OK_OUT), .STATE_OUT(STATE_OUT));
`default_nettype wire
